// file: hdl/vsr_pkg.sv
package vsr_pkg;

  localparam int unsigned DIM_W   = 13;
  localparam int unsigned FSIZE_W = 2 * DIM_W;
  localparam int unsigned ADDR_W  = 12;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CONTROL  = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_ERROR    = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_VERSION  = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_FRM_CNT  = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_LINE_CNT = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_PIX_CNT  = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_DIMS     = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_PHASE    = 12'h100;

  // Field positions
  localparam int unsigned CTL_COMMIT_BIT   = 1;
  localparam int unsigned ST_BEGUN_BIT     = 0;
  localparam int unsigned ST_DONE_BIT      = 1;
  localparam int unsigned ST_ERROR_BIT     = 16;
  localparam int unsigned ST_W             = 17;
  localparam int unsigned ERR_LINE_EARLY   = 0;
  localparam int unsigned ERR_LINE_MISSING = 1;
  localparam int unsigned ERR_FRM_EARLY    = 2;
  localparam int unsigned ERR_FRM_MISSING  = 3;
  localparam int unsigned ERR_W            = 4;
  localparam int unsigned DIMS_WIDTH_LSB   = 0;
  localparam int unsigned DIMS_HEIGHT_LSB  = 16;
  localparam int unsigned PHASE_W          = 2;

  localparam int unsigned DIM_MIN    = 128;
  localparam int unsigned HEIGHT_MAX = 7680;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [PHASE_W-1:0] {
    VSR_PH_RED_RG,
    VSR_PH_GREEN_RG,
    VSR_PH_GREEN_BG,
    VSR_PH_BLUE_BG
  } vsr_phase_e;

  typedef struct packed {
    logic [DIM_W-1:0] height;
    logic [DIM_W-1:0] width;
    vsr_phase_e       phase;
  } vsr_cfg_s;

  typedef struct packed {
    logic frame_late;
    logic frame_early;
    logic line_end_missing;
    logic line_end_premature;
    logic frame_done;
    logic frame_begun;
  } vsr_evt_s;

endpackage

// file: hdl/vsr_regs.sv
// Overview of operation
// - Status bit 16 flags any recorded framing error
// - Status and error flags stay set
// - Error bits clear individually by writing one
// - Error 0: line ended before programmed width
// - Error 1: line ran past programmed width
// - Error 2: frame start before frame size
// - Error 3: frame ran past frame size
// - Interrupt is OR of masked status bits
// - Interrupt is a level while enabled bits set
// - Status bits 0 and 1 clear by host writing one
// - Version register read-only, fixed fields
// - Read-only 32-bit frame counter, cleared by reset
// - Read-only 32-bit line counter, cleared by reset
// - Read-only 32-bit pixel counter, cleared by reset
// - Dimensions bits 12:0 hold pixels per line
// - Dimensions bits 28:16 hold lines per frame
// - Phase bits 1:0 select mosaic start arrangement
// - Framing detection works without register interface
// - Interrupt output exists only with register interface
// - Event vector: begin, done, line, frame errors
// - Event vector bits are not latched
// - Status 0 on frame begin, 1 on done
// - Dimensions and phase double buffered, commit gated
module vsr_regs
  import vsr_pkg::*;
#(
  parameter bit                  HAS_REGS     = 1'b1,
  parameter int unsigned         MAX_WIDTH    = 7680,
  parameter logic [DIM_W-1:0]    DEF_WIDTH    = 13'h0780,
  parameter logic [DIM_W-1:0]    DEF_HEIGHT   = 13'h0438,
  parameter logic [PHASE_W-1:0]  DEF_PHASE    = 2'h0,
  // Arbitrary identification value
  parameter logic [31:0]         VERSION_WORD = 32'h0100_0000
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Stream being monitored
  input  wire logic              s_axis_tvalid,
  output logic                   s_axis_tready,
  input  wire logic              s_axis_tuser,
  input  wire logic              s_axis_tlast,
  // Register port
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Status side
  output logic                   irq,
  output vsr_evt_s               parallel_event_vector,
  output vsr_cfg_s               active_cfg
);

  // Both dimension fields are DIM_W bits wide; the line counter has one bit more
  if (MAX_WIDTH < DIM_MIN || MAX_WIDTH >= (1 << DIM_W)) begin
    $error("MAX_WIDTH out of range");
  end
  if (HEIGHT_MAX >= (1 << DIM_W)) begin
    $error("HEIGHT_MAX does not fit the height field");
  end
  if (DEF_WIDTH < DIM_MIN || DEF_WIDTH > MAX_WIDTH) begin
    $error("DEF_WIDTH out of range");
  end
  if (DEF_HEIGHT < DIM_MIN || DEF_HEIGHT > HEIGHT_MAX) begin
    $error("DEF_HEIGHT out of range");
  end

  localparam vsr_cfg_s CFG_RESET = '{height: DEF_HEIGHT, width: DEF_WIDTH,
                                     phase: vsr_phase_e'(DEF_PHASE)};

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // ---------------- Stream monitor ----------------
  logic                     tready_q;
  logic                     xfer;
  logic [DIM_W:0]           line_pix_q;
  logic [FSIZE_W:0]         frame_pix_q;
  logic [FSIZE_W:0]         frame_pix_nx;
  logic [FSIZE_W-1:0]       frame_size;
  logic                     sof_seen_q;
  vsr_cfg_s                 act_q;
  vsr_cfg_s                 host_q;
  logic                     commit_q;
  vsr_evt_s                 evt_d;
  vsr_evt_s                 evt_q;

  // The monitor never stalls the source; it only observes transfers
  always_ff @(posedge clk) begin
    if (!rst_n) tready_q <= 1'b0;
    else        tready_q <= 1'b1;
  end

  assign xfer       = s_axis_tvalid & tready_q;
  assign frame_size = FSIZE_W'(act_q.width * act_q.height);
  assign frame_pix_nx = s_axis_tuser ? (FSIZE_W+1)'(1) : frame_pix_q + 1'b1;

  // Detection runs with or without the register port
  always_comb begin
    evt_d = '0;
    if (xfer) begin
      evt_d.frame_begun = s_axis_tuser;
      // Pixels ahead of the first start marker belong to no frame
      evt_d.frame_done  = (s_axis_tuser || sof_seen_q)
                          && (frame_pix_nx == {1'b0, frame_size});
      if (s_axis_tlast)
        evt_d.line_end_premature = (line_pix_q + 1'b1) < {1'b0, act_q.width};
      else
        evt_d.line_end_missing = (line_pix_q == {1'b0, act_q.width});
      if (s_axis_tuser)
        evt_d.frame_early = sof_seen_q && (frame_pix_q < {1'b0, frame_size});
      else
        evt_d.frame_late = sof_seen_q && (frame_pix_q == {1'b0, frame_size});
    end
  end

  // Counts saturate one past the limit so an overrun reports once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_pix_q <= '0;
    end else if (xfer) begin
      if (s_axis_tlast)
        line_pix_q <= '0;
      else if (line_pix_q <= {1'b0, act_q.width})
        line_pix_q <= line_pix_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_pix_q <= '0;
      sof_seen_q  <= 1'b0;
    end else if (xfer) begin
      if (s_axis_tuser) sof_seen_q <= 1'b1;
      if (s_axis_tuser || frame_pix_q <= {1'b0, frame_size})
        frame_pix_q <= frame_pix_nx;
    end
  end

  // Host set moves to the active set at frame end only when committed
  always_ff @(posedge clk) begin
    if (!rst_n)
      act_q <= CFG_RESET;
    else if (evt_d.frame_done && commit_q)
      act_q <= host_q;
  end

  // Not held: each bit follows its event, one cycle late
  always_ff @(posedge clk) begin
    if (!rst_n) evt_q <= '0;
    else        evt_q <= evt_d;
  end

  // ---------------- Throughput counters ----------------
  logic [31:0] frm_cnt_q;
  logic [31:0] line_cnt_q;
  logic [31:0] pix_cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frm_cnt_q  <= '0;
      line_cnt_q <= '0;
      pix_cnt_q  <= '0;
    end else begin
      if (evt_d.frame_done)      frm_cnt_q  <= frm_cnt_q + 1'b1;
      if (xfer && s_axis_tlast)  line_cnt_q <= line_cnt_q + 1'b1;
      if (xfer)                  pix_cnt_q  <= pix_cnt_q + 1'b1;
    end
  end

  // ---------------- Register port ----------------
  logic              awready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic              wr_fire;
  logic              rd_fire;
  logic [ERR_W-1:0]  err_q;
  logic [ST_W-1:0]   status_q;
  logic [ST_W-1:0]   mask_q;
  logic              irq_q;
  logic [31:0]       wr_mask;
  logic [31:0]       rd_word;
  logic              rd_hit;
  logic              wr_hit;
  logic [ERR_W-1:0]  err_evt;
  logic              st_wr;
  logic              err_wr;

  // Address and data are taken together; the master holds both valid
  assign wr_fire = HAS_REGS && awready_q && s_axi_awvalid && s_axi_wvalid;
  assign rd_fire = HAS_REGS && arready_q && s_axi_arvalid;
  assign wr_mask = merge_strb(32'h0000_0000, s_axi_wdata, s_axi_wstrb);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      awready_q <= HAS_REGS && !awready_q && !bvalid_q
                   && s_axi_awvalid && s_axi_wvalid;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    if (s_axi_awaddr == OFF_CONTROL)       wr_hit = 1'b1;
    else if (s_axi_awaddr == OFF_STATUS)   wr_hit = 1'b1;
    else if (s_axi_awaddr == OFF_ERROR)    wr_hit = 1'b1;
    else if (s_axi_awaddr == OFF_IRQ_MASK) wr_hit = 1'b1;
    else if (s_axi_awaddr == OFF_VERSION)  wr_hit = 1'b1;
    else if (s_axi_awaddr == OFF_FRM_CNT)  wr_hit = 1'b1;
    else if (s_axi_awaddr == OFF_LINE_CNT) wr_hit = 1'b1;
    else if (s_axi_awaddr == OFF_PIX_CNT)  wr_hit = 1'b1;
    else if (s_axi_awaddr == OFF_DIMS)     wr_hit = 1'b1;
    else if (s_axi_awaddr == OFF_PHASE)    wr_hit = 1'b1;
    else                                   wr_hit = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      commit_q <= 1'b0;
      mask_q   <= '0;
      host_q   <= CFG_RESET;
    end else if (wr_fire) begin
      if (s_axi_awaddr == OFF_CONTROL) begin
        if (s_axi_wstrb[0]) commit_q <= s_axi_wdata[CTL_COMMIT_BIT];
      end else if (s_axi_awaddr == OFF_IRQ_MASK) begin
        mask_q <= ST_W'(merge_strb(32'(mask_q), s_axi_wdata, s_axi_wstrb));
      end else if (s_axi_awaddr == OFF_DIMS) begin
        if (s_axi_wstrb[0]) host_q.width[7:0] <= s_axi_wdata[7:0];
        if (s_axi_wstrb[1]) host_q.width[DIM_W-1:8] <= s_axi_wdata[DIM_W-1:8];
        if (s_axi_wstrb[2])
          host_q.height[7:0] <= s_axi_wdata[DIMS_HEIGHT_LSB +: 8];
        if (s_axi_wstrb[3])
          host_q.height[DIM_W-1:8] <= s_axi_wdata[DIMS_HEIGHT_LSB+8 +: DIM_W-8];
      end else if (s_axi_awaddr == OFF_PHASE) begin
        if (s_axi_wstrb[0])
          host_q.phase <= vsr_phase_e'(s_axi_wdata[PHASE_W-1:0]);
      end
    end
  end

  // Error events in register bit order
  always_comb begin
    err_evt                   = '0;
    err_evt[ERR_LINE_EARLY]   = evt_d.line_end_premature;
    err_evt[ERR_LINE_MISSING] = evt_d.line_end_missing;
    err_evt[ERR_FRM_EARLY]    = evt_d.frame_early;
    err_evt[ERR_FRM_MISSING]  = evt_d.frame_late;
  end

  assign st_wr  = wr_fire && (s_axi_awaddr == OFF_STATUS);
  assign err_wr = wr_fire && (s_axi_awaddr == OFF_ERROR);

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_q <= '0;
    end else begin
      for (int i = 0; i < ERR_W; i++) begin
        if (err_evt[i])
          err_q[i] <= 1'b1;
        else if (err_wr && wr_mask[i])
          err_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      if (evt_d.frame_begun)
        status_q[ST_BEGUN_BIT] <= 1'b1;
      else if (st_wr && wr_mask[ST_BEGUN_BIT])
        status_q[ST_BEGUN_BIT] <= 1'b0;
      if (evt_d.frame_done)
        status_q[ST_DONE_BIT] <= 1'b1;
      else if (st_wr && wr_mask[ST_DONE_BIT])
        status_q[ST_DONE_BIT] <= 1'b0;
      // Summary follows the sticky error bits, including new ones
      status_q[ST_ERROR_BIT] <= |err_q || |err_evt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) irq_q <= 1'b0;
    else        irq_q <= HAS_REGS && |(status_q & mask_q);
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr == OFF_CONTROL)       rd_word[CTL_COMMIT_BIT] = commit_q;
    else if (s_axi_araddr == OFF_STATUS)   rd_word[ST_W-1:0] = status_q;
    else if (s_axi_araddr == OFF_ERROR)    rd_word[ERR_W-1:0] = err_q;
    else if (s_axi_araddr == OFF_IRQ_MASK) rd_word[ST_W-1:0] = mask_q;
    else if (s_axi_araddr == OFF_VERSION)  rd_word = VERSION_WORD;
    else if (s_axi_araddr == OFF_FRM_CNT)  rd_word = frm_cnt_q;
    else if (s_axi_araddr == OFF_LINE_CNT) rd_word = line_cnt_q;
    else if (s_axi_araddr == OFF_PIX_CNT)  rd_word = pix_cnt_q;
    else if (s_axi_araddr == OFF_DIMS) begin
      rd_word[DIMS_WIDTH_LSB +: DIM_W]  = host_q.width;
      rd_word[DIMS_HEIGHT_LSB +: DIM_W] = host_q.height;
    end else if (s_axi_araddr == OFF_PHASE) rd_word[PHASE_W-1:0] = host_q.phase;
    else                                    rd_hit = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
    end else begin
      arready_q <= HAS_REGS && !arready_q && !rvalid_q && s_axi_arvalid;
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axis_tready         = tready_q;
  assign s_axi_awready         = awready_q;
  assign s_axi_wready          = awready_q;
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_arready         = arready_q;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rresp           = rresp_q;
  assign s_axi_rdata           = rdata_q;
  assign irq                   = irq_q;
  assign parallel_event_vector = evt_q;
  assign active_cfg            = act_q;

endmodule

// file: sim/vsr_regs_props.sv
module vsr_regs_props
  import vsr_pkg::*;
(
  input wire logic     clk,
  input wire logic     rst_n,
  input wire logic     s_axis_tvalid,
  input wire logic     s_axis_tready,
  input wire logic     s_axis_tuser,
  input wire logic     s_axis_tlast,
  input wire logic     s_axi_awvalid,
  input wire logic     s_axi_wvalid,
  input wire logic     s_axi_awready,
  input wire logic     s_axi_wready,
  input wire logic     s_axi_bvalid,
  input wire logic     s_axi_bready,
  input wire logic     s_axi_arvalid,
  input wire logic     s_axi_arready,
  input wire logic     s_axi_rvalid,
  input wire logic     irq,
  input wire vsr_evt_s parallel_event_vector
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence pix_in; s_axis_tvalid && s_axis_tready; endsequence
  sequence wr_take; s_axi_awready && s_axi_awvalid && s_axi_wvalid; endsequence
  sequence rd_take; s_axi_arready && s_axi_arvalid; endsequence

  stream_ready_a: assert property ($past(rst_n) |-> s_axis_tready)
    else $error("stream input not ready after reset");
  begin_evt_a: assert property (pix_in ##0 s_axis_tuser |=> parallel_event_vector[0])
    else $error("frame start pixel gave no begin event");
  evt_cause_a: assert property (|parallel_event_vector |-> $past(s_axis_tvalid && s_axis_tready))
    else $error("event without a pixel the cycle before");
  line_early_a: assert property (parallel_event_vector[2] |-> $past(s_axis_tlast))
    else $error("premature line end without line end marker");
  line_late_a: assert property (parallel_event_vector[3] |-> !$past(s_axis_tlast))
    else $error("missing line end flagged on a marked pixel");
  frame_early_a: assert property (parallel_event_vector[4] |-> $past(s_axis_tuser))
    else $error("early frame start without start marker");
  frame_late_a: assert property (parallel_event_vector[5] |-> !$past(s_axis_tuser))
    else $error("missing frame start flagged on a start pixel");
  irq_level_a: assert property ($fell(irq) |-> $past(s_axi_awready, 2) || $past(s_axi_awready, 3))
    else $error("interrupt dropped without a host write");
  wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("write taken without a response");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before it was taken");
  wready_pair_a: assert property (s_axi_wready == s_axi_awready)
    else $error("write data ready differs from address ready");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read taken without data");
endmodule

bind vsr_regs vsr_regs_props vsr_regs_props_i (
  .clk, .rst_n, .s_axis_tvalid, .s_axis_tready, .s_axis_tuser, .s_axis_tlast, .s_axi_awvalid,
  .s_axi_wvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready,
  .s_axi_rvalid, .irq, .parallel_event_vector
);

// file: sim/vsr_host.sv
module vsr_host
  import vsr_pkg::*;
(
  input  wire logic              clk,
  output logic [ADDR_W-1:0]      s_axi_awaddr,
  output logic                   s_axi_awvalid,
  input  wire logic              s_axi_awready,
  output logic [31:0]            s_axi_wdata,
  output logic [3:0]             s_axi_wstrb,
  output logic                   s_axi_wvalid,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_bvalid,
  output logic                   s_axi_bready,
  output logic [ADDR_W-1:0]      s_axi_araddr,
  output logic                   s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [31:0]       s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  output logic                   s_axi_rready
);
  timeunit 1ns;
  timeprecision 100ps;
  int to_cnt = 0;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
  end
  // Flags are cleared by writing ones; released lines show the inverse so stale values never pass
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_awaddr = a;
    s_axi_wdata = d;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid = 1'b1;
    n = 0;
    // Ready is read once settled, then held over the edge that takes the request
    do begin @(posedge clk); #1; n++; end while (!s_axi_awready && n < 64);
    @(posedge clk);
    #1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_awaddr = ~a;
    s_axi_wdata = ~d;
    s_axi_bready = 1'b1;
    while (!s_axi_bvalid && n < 128) begin @(posedge clk); #1; n++; end
    r = s_axi_bresp;
    @(posedge clk);
    #1;
    s_axi_bready = 1'b0;
    if (n >= 100) to_cnt++;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (!s_axi_arready && n < 64);
    @(posedge clk);
    #1;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = ~a;
    s_axi_rready = 1'b1;
    while (!s_axi_rvalid && n < 128) begin @(posedge clk); #1; n++; end
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk);
    #1;
    s_axi_rready = 1'b0;
    if (n >= 100) to_cnt++;
  endtask
endmodule

// file: sim/tb_video_status_irq_registers.sv
module tb_video_status_irq_registers
  import vsr_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int W = 128;
  localparam int H = 128;
  localparam logic [ADDR_W-1:0] UNMAPPED = 12'h040;
  // Arbitrary identification value
  localparam logic [31:0] VER = 32'h0A5A_0001;
  logic clk, rst_n, s_axis_tvalid, s_axis_tready, s_axis_tuser, s_axis_tlast, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, err;
  logic [1:0] s_axi_bresp, s_axi_rresp, st, ph;
  logic [31:0] msk;
  vsr_evt_s parallel_event_vector;
  vsr_cfg_s active_cfg;
  logic irq_nb;
  vsr_evt_s evt_nb;
  int fail_count = 0;
  int n_checks = 0;
  int seed = 32'h0090;
  int lc, fc, pc, ln, fr;
  bit sof;
  logic [ADDR_W-1:0] ra [9] = '{OFF_STATUS, OFF_ERROR, OFF_IRQ_MASK, OFF_VERSION, OFF_FRM_CNT,
                                OFF_LINE_CNT, OFF_PIX_CNT, OFF_DIMS, OFF_PHASE};
  logic [31:0] rv [9] = '{32'h0, 32'h0, 32'h0, VER, 32'h0, 32'h0, 32'h0, 32'h0080_0080, 32'h0};

  vsr_regs #(.DEF_WIDTH(13'h0080), .DEF_HEIGHT(13'h0080), .VERSION_WORD(VER)) vsr_regs_i (
    .clk, .rst_n, .s_axis_tvalid, .s_axis_tready, .s_axis_tuser, .s_axis_tlast,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq, .parallel_event_vector, .active_cfg
  );
  // Same stream, no register port: detection must still run, interrupt must stay low
  vsr_regs #(.HAS_REGS(1'b0), .DEF_WIDTH(13'h0080), .DEF_HEIGHT(13'h0080)) vsr_regs_nobus_i (
    .clk, .rst_n, .s_axis_tvalid, .s_axis_tready(), .s_axis_tuser, .s_axis_tlast,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready, .irq(irq_nb), .parallel_event_vector(evt_nb),
    .active_cfg()
  );
  vsr_host vsr_host_i (
    .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  function automatic logic [31:0] stv();
    return {15'h0, |err, 14'h0, st};
  endfunction
  task automatic w(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [1:0] rs;
    vsr_host_i.wr(a, d, rs);
    chk({30'h0, rs}, {30'h0, ((a == UNMAPPED) ? RESP_SLVERR : RESP_OKAY)}, "write resp");
    if (a == OFF_STATUS) st &= ~d[1:0];
    if (a == OFF_ERROR) err &= ~d[3:0];
    if (a == OFF_IRQ_MASK) msk = d & 32'h0001_FFFF;
    repeat (3) @(posedge clk);
    #1;
    chk({31'h0, irq}, {31'h0, |(stv() & msk)}, "irq level");
    chk({31'h0, irq_nb}, 32'h0, "irq without register port");
  endtask
  task automatic r(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] rs;
    vsr_host_i.rd(a, d, rs);
    chk(d, e, "read data");
    chk({30'h0, rs}, {30'h0, ((a == UNMAPPED) ? RESP_SLVERR : RESP_OKAY)}, "read resp");
  endtask
  // Random gaps in valid make sure idle cycles never count as pixels
  task automatic pix(input bit u, input bit l);
    logic [5:0] ev;
    bit v;
    v = 1'b0;
    while (!v) begin
      v = ($random(seed) & 3) != 0;
      s_axis_tvalid = v;
      s_axis_tuser = u;
      s_axis_tlast = l;
      @(posedge clk);
      #1;
      ev = '0;
      if (v) begin
        pc++;
        lc++;
        fc++;
        ev[4] = u && sof && fc - 1 < W * H;
        ev[5] = !u && sof && fc == W * H + 1;
        if (u) fc = 1;
        sof |= u;
        ev[0] = u;
        ev[1] = sof && fc == W * H;
        ev[2] = l && lc < W;
        ev[3] = !l && lc == W + 1;
        if (l) lc = 0;
        err |= ev[5:2];
        st |= ev[1:0];
        ln += l;
        fr += ev[1];
      end
      chk({26'h0, parallel_event_vector}, {26'h0, ev}, "event vector");
      chk({26'h0, evt_nb}, {26'h0, ev}, "events without register port");
    end
  endtask
  task automatic line(input int n, input bit u, input bit l);
    for (int i = 0; i < n; i++) pix(u && i == 0, l && i == n - 1);
  endtask
  task automatic test_done();
    fail_count += vsr_host_i.to_cnt;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    test_done();
  end
  initial begin
    {s_axis_tvalid, s_axis_tuser, s_axis_tlast, rst_n, sof} = '0;
    {lc, fc, pc, ln, fr} = '0;
    {err, st, msk} = '0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    for (int i = 0; i < 9; i++) r(ra[i], rv[i]);
    w(OFF_VERSION, 32'h0);
    r(OFF_VERSION, VER);
    w(UNMAPPED, 32'hFFFF_FFFF);
    r(UNMAPPED, 32'h0);
    $display("test reset_values done");
    w(OFF_IRQ_MASK, 32'hFFFF_FFFF);
    r(OFF_IRQ_MASK, 32'h0001_FFFF);
    ph = 2'(1 + $unsigned($random(seed)) % 3);
    w(OFF_DIMS, 32'h0080_0080);
    w(OFF_PHASE, {30'h0, ph});
    w(OFF_CONTROL, 32'h2);
    chk({4'h0, active_cfg}, {4'h0, 13'h0080, 13'h0080, 2'h0}, "config held");
    for (int k = 0; k < H; k++) line(W, k == 0, 1'b1);
    s_axis_tvalid = 1'b0;
    chk({4'h0, active_cfg}, {4'h0, 13'h0080, 13'h0080, ph}, "config commit");
    r(OFF_STATUS, stv());
    r(OFF_PIX_CNT, 32'(pc));
    r(OFF_FRM_CNT, 32'(fr));
    r(OFF_LINE_CNT, 32'(ln));
    w(OFF_STATUS, 32'h1);
    w(OFF_STATUS, 32'h2);
    r(OFF_STATUS, stv());
    $display("test frame_and_status done");
    w(OFF_IRQ_MASK, 32'h0001_0000);
    line(100, 1'b1, 1'b1);
    line(130, 1'b0, 1'b1);
    s_axis_tvalid = 1'b0;
    r(OFF_ERROR, {28'h0, err});
    for (int k = 0; k <= H; k++) line(W, k == 0, 1'b1);
    s_axis_tvalid = 1'b0;
    r(OFF_ERROR, {28'h0, err});
    r(OFF_STATUS, stv());
    w(OFF_ERROR, 32'h0);
    w(OFF_ERROR, 32'h5);
    r(OFF_ERROR, {28'h0, err});
    w(OFF_ERROR, 32'hF);
    r(OFF_STATUS, stv());
    r(OFF_FRM_CNT, 32'(fr));
    r(OFF_LINE_CNT, 32'(ln));
    $display("test framing_errors done");
    test_done();
  end
endmodule
